// [core/abr_bp_params.svh]
`ifndef ABR_BP_PARAMS_SVH
`define ABR_BP_PARAMS_SVH

// ****************************************************************
// structure of the branch point
// ****************************************************************
`define ABR_NUM_BRANCH 4
`define ABR_PAYLOAD_W 16
`define ABR_FIFO_DEPTH 4
`define ABR_CNT_W 16
`define ABR_TIMER_W 16

// ****************************************************************
// values
// ****************************************************************
// explicit rate meaning "no restriction", start of every min search
`define ABR_ER_MAX 16'hFFFF
`define ABR_CNT_ZERO 16'h0000
`define ABR_TIMER_ZERO 16'h0000

// ****************************************************************
// timing
// ****************************************************************
`define ABR_CLK_MHZ 20
// silence before a branch is declared non-responding, in microseconds
`define ABR_IDLE_TIME_US 500
`define ABR_IDLE_CYCLES (`ABR_IDLE_TIME_US * `ABR_CLK_MHZ)

`endif

// [core/abr_bp_pkg.sv]
`include "abr_bp_params.svh"

package abr_bp_pkg;

  // ****************************************************************
  // cell kinds and cell layout
  // ****************************************************************
  typedef enum logic [1:0] {
    CELL_DATA = 2'h0,
    CELL_FRM = 2'h1,
    CELL_BRM = 2'h2,
    CELL_BRM_OOR = 2'h3
  } cell_kind_t;

  typedef struct packed {
    cell_kind_t kind;
    logic [`ABR_PAYLOAD_W-1:0] payload;
  } cell_t;

  // consolidation engine, one-hot
  typedef enum logic [1:0] {
    CS_COLLECT = 2'b01,
    CS_SEND = 2'b10
  } cons_state_t;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic is_back_rm(input cell_kind_t k);
    return (k == CELL_BRM) || (k == CELL_BRM_OOR);
  endfunction : is_back_rm

  function automatic logic [`ABR_PAYLOAD_W-1:0] min_er(input logic [`ABR_PAYLOAD_W-1:0] a,
                                                      input logic [`ABR_PAYLOAD_W-1:0] b);
    return (a < b) ? a : b;
  endfunction : min_er

  function automatic logic [`ABR_CNT_W-1:0] count_ones(input logic [`ABR_NUM_BRANCH-1:0] v);
    logic [`ABR_CNT_W-1:0] n;
    n = `ABR_CNT_ZERO;
    for (int i = 0; i < `ABR_NUM_BRANCH; i++) begin
      n = n + `ABR_CNT_W'(v[i]);
    end
    return n;
  endfunction : count_ones

endpackage : abr_bp_pkg

// [core/abr_branch_point.sv]
// Function
// - forward RM out, backward RM carries feedback back
// - copy data and forward RM to every branch
// - merge backward RMs, one per round to root
// - silent branch may be flagged non-responding
// - consolidation may ignore non-responding branches
// - drops on non-responding branches excluded from loss
// - no user data passes from leaves to root
// - zero return rates allow only out-of-rate RMs
// - one return-path rate setting for all leaves
// - branches and leaves always accept cells
// - branch flows follow point-to-point conformance
// - optional virtual source/destination splits the loop
`timescale 1ns/1ps
`include "abr_bp_params.svh"

module abr_branch_point
  import abr_bp_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = `ABR_IDLE_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // forward cells from the root
  input wire logic root_in_valid,
  output logic root_in_ready,
  input wire cell_kind_t root_in_kind,
  input wire logic [`ABR_PAYLOAD_W-1:0] root_in_payload,
  // replicated cells toward the leaves
  output logic [`ABR_NUM_BRANCH-1:0] leaf_out_valid,
  input wire logic [`ABR_NUM_BRANCH-1:0] leaf_out_ready,
  output cell_kind_t leaf_out_kind [`ABR_NUM_BRANCH],
  output logic [`ABR_PAYLOAD_W-1:0] leaf_out_payload [`ABR_NUM_BRANCH],
  // cells coming back from the leaves
  input wire logic [`ABR_NUM_BRANCH-1:0] leaf_in_valid,
  output logic [`ABR_NUM_BRANCH-1:0] leaf_in_ready,
  input wire cell_kind_t leaf_in_kind [`ABR_NUM_BRANCH],
  input wire logic [`ABR_PAYLOAD_W-1:0] leaf_in_payload [`ABR_NUM_BRANCH],
  // consolidated feedback toward the root
  output logic root_bk_valid,
  input wire logic root_bk_ready,
  output cell_kind_t root_bk_kind,
  output logic [`ABR_PAYLOAD_W-1:0] root_bk_payload,
  // configuration
  input wire logic cfg_vs_enable,
  input wire logic cfg_ret_zero_rate,
  // status
  output logic [`ABR_NUM_BRANCH-1:0] branch_nonresp,
  output logic [`ABR_CNT_W-1:0] loss_count,
  output logic [`ABR_CNT_W-1:0] nonresp_drop_count,
  output logic [`ABR_CNT_W-1:0] upstream_reject_count
);
  localparam int NB = `ABR_NUM_BRANCH;
  localparam int CELL_W = $bits(cell_t);
  localparam logic [`ABR_TIMER_W-1:0] IDLE_LAST = `ABR_TIMER_W'(IDLE_CYCLES - 1);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta, rst_n;

  // assertion is immediate, release waits two edges
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************************************
  // root-side buffer
  // ****************************************************************
  cell_stream_if #(.WIDTH(CELL_W)) fifo_in ();
  cell_stream_if #(.WIDTH(CELL_W)) fifo_out ();
  cell_t head;
  logic fire;

  assign fifo_in.valid = root_in_valid;
  assign fifo_in.data = {root_in_kind, root_in_payload};
  assign root_in_ready = fifo_in.ready;
  assign head = cell_t'(fifo_out.data);
  assign fifo_out.ready = fire;

  cell_fifo #(
    .WIDTH(CELL_W),
    .DEPTH(`ABR_FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .push(fifo_in),
    .pop(fifo_out)
  );

  // ****************************************************************
  // replication toward the leaves
  // ****************************************************************
  cons_state_t state, next_state;
  logic [NB-1:0] slot_free, load, drop, next_leaf_out_valid;
  cell_kind_t next_leaf_out_kind [NB];
  logic [`ABR_PAYLOAD_W-1:0] next_leaf_out_payload [NB];
  logic turnaround, blocked;

  // a cell bound for the leaves leaves the buffer only when every live branch can take it;
  // a dead branch never stalls the tree, its copy is discarded instead
  always_comb begin
    slot_free = ~leaf_out_valid | leaf_out_ready;
    turnaround = cfg_vs_enable && fifo_out.valid && (head.kind == CELL_FRM);
    blocked = |(~branch_nonresp & ~slot_free);
    if (turnaround) begin
      fire = fifo_out.valid && (state == CS_COLLECT);
    end else begin
      fire = fifo_out.valid && !blocked;
    end
    load = '0;
    drop = '0;
    if (fire && !turnaround) begin
      load = slot_free;
      drop = ~slot_free;
    end
    for (int i = 0; i < NB; i++) begin
      // a copy stands until taken, as on a point-to-point link
      next_leaf_out_valid[i] = load[i] | (leaf_out_valid[i] & ~leaf_out_ready[i]);
      next_leaf_out_kind[i] = load[i] ? head.kind : leaf_out_kind[i];
      next_leaf_out_payload[i] = load[i] ? head.payload : leaf_out_payload[i];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      leaf_out_valid <= '0;
      for (int i = 0; i < NB; i++) begin
        leaf_out_kind[i] <= CELL_DATA;
        leaf_out_payload[i] <= '0;
      end
    end else begin
      leaf_out_valid <= next_leaf_out_valid;
      for (int i = 0; i < NB; i++) begin
        leaf_out_kind[i] <= next_leaf_out_kind[i];
        leaf_out_payload[i] <= next_leaf_out_payload[i];
      end
    end
  end

  // ****************************************************************
  // return path filter and idle timers
  // ****************************************************************
  logic [NB-1:0] rm_seen, accept, reject, next_branch_nonresp;
  logic [`ABR_TIMER_W-1:0] idle_timer [NB];
  logic [`ABR_TIMER_W-1:0] next_idle_timer [NB];
  logic [`ABR_PAYLOAD_W-1:0] new_min;

  // every leaf is judged against the same return-path setting
  always_comb begin
    new_min = `ABR_ER_MAX;
    for (int i = 0; i < NB; i++) begin
      rm_seen[i] = leaf_in_valid[i] && (leaf_in_kind[i] != CELL_DATA);
      accept[i] = leaf_in_valid[i] && is_back_rm(leaf_in_kind[i])
                  && !(cfg_ret_zero_rate && leaf_in_kind[i] == CELL_BRM);
      reject[i] = leaf_in_valid[i] && !accept[i];
      if (accept[i]) begin
        new_min = min_er(new_min, leaf_in_payload[i]);
      end
      // silence counts up; any RM-cell revives the branch
      if (rm_seen[i]) begin
        next_idle_timer[i] = `ABR_TIMER_ZERO;
        next_branch_nonresp[i] = 1'b0;
      end else if (idle_timer[i] == IDLE_LAST) begin
        next_idle_timer[i] = idle_timer[i];
        next_branch_nonresp[i] = 1'b1;
      end else begin
        next_idle_timer[i] = idle_timer[i] + 1'b1;
        next_branch_nonresp[i] = branch_nonresp[i];
      end
    end
  end

  // leaves are never back-pressured, so accept is held high after reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      leaf_in_ready <= '0;
      branch_nonresp <= '0;
      for (int i = 0; i < NB; i++) begin
        idle_timer[i] <= `ABR_TIMER_ZERO;
      end
    end else begin
      leaf_in_ready <= '1;
      branch_nonresp <= next_branch_nonresp;
      for (int i = 0; i < NB; i++) begin
        idle_timer[i] <= next_idle_timer[i];
      end
    end
  end

  // ****************************************************************
  // feedback consolidation
  // ****************************************************************
  logic [NB-1:0] reported, next_reported;
  logic [`ABR_PAYLOAD_W-1:0] acc_er, next_acc_er, next_root_bk_payload;
  logic next_root_bk_valid, round_done;
  cell_kind_t next_root_bk_kind;

  // one backward RM-cell per round, whatever the number of leaves;
  // with the virtual destination on, the root's own forward RM-cell
  // paces the rounds instead and leaf feedback is only folded in
  always_comb begin
    next_state = state;
    next_reported = reported | accept;
    next_acc_er = min_er(acc_er, new_min);
    next_root_bk_kind = root_bk_kind;
    next_root_bk_payload = root_bk_payload;
    round_done = !cfg_vs_enable && (&(next_reported | branch_nonresp)) && (|next_reported);
    unique case (state)
      CS_COLLECT: begin
        if ((fire && turnaround) || round_done) begin
          next_state = CS_SEND;
          next_root_bk_payload = next_acc_er;
          next_root_bk_kind = cfg_ret_zero_rate ? CELL_BRM_OOR : CELL_BRM;
          next_reported = '0;
          next_acc_er = `ABR_ER_MAX;
        end
      end
      CS_SEND: begin
        if (root_bk_ready) begin
          next_state = CS_COLLECT;
        end
      end
    endcase
    next_root_bk_valid = (next_state == CS_SEND);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CS_COLLECT;
      reported <= '0;
      acc_er <= `ABR_ER_MAX;
      root_bk_valid <= 1'b0;
      root_bk_kind <= CELL_BRM;
      root_bk_payload <= '0;
    end else begin
      state <= next_state;
      reported <= next_reported;
      acc_er <= next_acc_er;
      root_bk_valid <= next_root_bk_valid;
      root_bk_kind <= next_root_bk_kind;
      root_bk_payload <= next_root_bk_payload;
    end
  end

  // ****************************************************************
  // accounting
  // ****************************************************************
  logic [`ABR_CNT_W-1:0] next_loss_count, next_nonresp_drop_count, next_upstream_reject_count;

  // a root cell offered without room is lost; dead-branch copies go
  // to their own counter so they never weigh on the loss figure
  always_comb begin
    next_loss_count = loss_count + `ABR_CNT_W'(root_in_valid && !root_in_ready);
    next_nonresp_drop_count = nonresp_drop_count + count_ones(drop);
    next_upstream_reject_count = upstream_reject_count + count_ones(reject);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_count <= `ABR_CNT_ZERO;
      nonresp_drop_count <= `ABR_CNT_ZERO;
      upstream_reject_count <= `ABR_CNT_ZERO;
    end else begin
      loss_count <= next_loss_count;
      nonresp_drop_count <= next_nonresp_drop_count;
      upstream_reject_count <= next_upstream_reject_count;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_emit;
    (state == CS_COLLECT) ##1 (state == CS_SEND);
  endsequence

  sequence seq_taken;
    root_bk_valid && root_bk_ready;
  endsequence

  a_no_data_up: assert property (root_bk_valid |-> is_back_rm(root_bk_kind))
    else $error("non-RM cell sent toward the root");

  a_zero_rate_oor: assert property ((state == CS_COLLECT) && (next_state == CS_SEND) && cfg_ret_zero_rate
    |=> root_bk_valid && root_bk_kind == CELL_BRM_OOR)
    else $error("in-rate RM sent on zero-rate return path");

  a_one_per_round: assert property (seq_emit ##0 seq_taken[*1] |=> !root_bk_valid)
    else $error("second backward RM without a new round");

  a_vs_turnaround: assert property (fire && turnaround |=> root_bk_valid && $stable(leaf_out_payload[0]))
    else $error("forward RM not turned around by virtual destination");

  a_drop_not_loss: assert property ((|drop) && !(root_in_valid && !root_in_ready)
    |=> loss_count == $past(loss_count) && nonresp_drop_count != $past(nonresp_drop_count))
    else $error("dead-branch drop charged as loss");

  a_leaf_accept: assert property ($past(rst_n) |-> &leaf_in_ready)
    else $error("leaf input not accepted");

  generate
    for (genvar g = 0; g < NB; g++) begin : g_chk
      a_copy_branch: assert property (fire && !turnaround && !branch_nonresp[g]
        |=> leaf_out_valid[g] && leaf_out_payload[g] == $past(head.payload))
        else $error("root cell not copied to live branch");

      a_idle_expiry: assert property (idle_timer[g] == IDLE_LAST && !rm_seen[g] |=> branch_nonresp[g])
        else $error("silent branch not marked non-responding");

      a_idle_revive: assert property (rm_seen[g] |=> !branch_nonresp[g] && idle_timer[g] == `ABR_TIMER_ZERO)
        else $error("RM-cell did not revive branch");
    end
  endgenerate

endmodule : abr_branch_point

// [core/cell_fifo.sv]
`timescale 1ns/1ps

// ****************************************************************
// small synchronous fifo, registered ready and valid
// ****************************************************************
module cell_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // streams
  cell_stream_if.snk push,
  cell_stream_if.src pop
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic in_ready, next_in_ready, out_valid, next_out_valid;
  logic do_push, do_pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  // ready and valid are computed ahead so both leave a flop
  always_comb begin
    do_push = push.valid && in_ready;
    do_pop = pop.ready && out_valid;
    next_wr_ptr = do_push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = do_pop ? bump(rd_ptr) : rd_ptr;
    next_count = count + CW'(do_push) - CW'(do_pop);
    next_in_ready = (next_count != CW'(DEPTH));
    next_out_valid = (next_count != '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
    end
  end

  // storage has no reset; nothing reads a slot before it is written
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push.data;
    end
  end

  assign push.ready = in_ready;
  assign pop.valid = out_valid;
  assign pop.data = mem[rd_ptr];

  a_fifo_full_stall: assert property (@(posedge clk) disable iff (!rst_n)
    count == CW'(DEPTH) |-> !push.ready)
    else $error("fifo offers room while full");

endmodule : cell_fifo

// [core/cell_stream_if.sv]
`timescale 1ns/1ps

// ****************************************************************
// valid/ready cell stream between the branch point and its buffer
// ****************************************************************
interface cell_stream_if #(
  parameter int WIDTH = 18
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : cell_stream_if

// [dv/leaf_far_model.sv]
`timescale 1ns/1ps

// ********
// leaf side: sinks for the copies, sources of feedback
// ********
module leaf_far_model
  import abr_bp_pkg::*;
(
  // clock
  input wire logic clk,
  // copies from the branch point
  input wire logic [3:0] out_valid,
  output logic [3:0] out_ready,
  input wire cell_kind_t out_kind [4],
  input wire logic [15:0] out_payload [4],
  // feedback toward the branch point
  output logic [3:0] in_valid,
  output cell_kind_t in_kind [4],
  output logic [15:0] in_payload [4],
  // control and observation
  input wire logic [3:0] stall,
  output logic [15:0] cnt [4],
  output logic [15:0] hsh [4],
  output cell_kind_t last_kind [4]
);
  // a leaf accepts at any time unless a test stalls it on purpose
  assign out_ready = ~stall;

  initial begin
    in_valid = 4'h0;
    for (int i = 0; i < 4; i++) begin
      in_kind[i] = CELL_DATA;
      in_payload[i] = 16'h0000;
      cnt[i] = 16'h0000;
      hsh[i] = 16'h0000;
      last_kind[i] = CELL_DATA;
    end
  end

  // order-sensitive signature, so a reordered or repeated copy shows up
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (out_valid[i] === 1'b1 && out_ready[i] === 1'b1) begin
        cnt[i] <= cnt[i] + 16'h0001;
        hsh[i] <= {hsh[i][14:0], hsh[i][15]} ^ out_payload[i];
        last_kind[i] <= out_kind[i];
      end
    end
  end

  // returns one cell per selected leaf for one cycle
  // data upstream only when a test asks for a refusal
  task automatic report(input logic [3:0] mask, input cell_kind_t k, input logic [63:0] er);
    @(negedge clk);
    in_valid = mask;
    for (int i = 0; i < 4; i++) begin
      in_kind[i] = k;
      in_payload[i] = er[i*16+:16];
    end
    @(negedge clk);
    in_valid = 4'h0;
    // released lines show the inverse so a stale value cannot pass
    for (int i = 0; i < 4; i++) begin
      in_kind[i] = cell_kind_t'(~in_kind[i]);
      in_payload[i] = ~in_payload[i];
    end
  endtask : report
endmodule : leaf_far_model

// [dv/tb_top.sv]
`timescale 1ns/1ps

module tb_top
  import abr_bp_pkg::*;
;
  // short idle limit keeps the silent-branch test quick
  localparam int IDLE = 40;
  logic core_clk, arst_n, root_in_valid, root_in_ready, root_bk_valid, root_bk_ready;
  cell_kind_t root_in_kind, root_bk_kind, bk_kind;
  logic [15:0] root_in_payload, root_bk_payload, bk_pay, loss_count, nonresp_drop_count, upstream_reject_count;
  logic [3:0] leaf_out_valid, leaf_out_ready, leaf_in_valid, leaf_in_ready, branch_nonresp, stall;
  cell_kind_t leaf_out_kind [4], leaf_in_kind [4], m_kind [4];
  logic [15:0] leaf_out_payload [4], leaf_in_payload [4], m_cnt [4], m_hsh [4], exp_cnt [4], exp_hsh [4];
  logic cfg_vs_enable, cfg_ret_zero_rate;
  int bad_count = 0;
  int check_count = 0;
  int bk_cnt = 0;
  int cycles = 0;

  abr_branch_point #(.IDLE_CYCLES(IDLE)) u_dut (
    .core_clk(core_clk), .arst_n(arst_n),
    .root_in_valid(root_in_valid), .root_in_ready(root_in_ready),
    .root_in_kind(root_in_kind), .root_in_payload(root_in_payload),
    .leaf_out_valid(leaf_out_valid), .leaf_out_ready(leaf_out_ready),
    .leaf_out_kind(leaf_out_kind), .leaf_out_payload(leaf_out_payload),
    .leaf_in_valid(leaf_in_valid), .leaf_in_ready(leaf_in_ready),
    .leaf_in_kind(leaf_in_kind), .leaf_in_payload(leaf_in_payload),
    .root_bk_valid(root_bk_valid), .root_bk_ready(root_bk_ready),
    .root_bk_kind(root_bk_kind), .root_bk_payload(root_bk_payload),
    .cfg_vs_enable(cfg_vs_enable), .cfg_ret_zero_rate(cfg_ret_zero_rate),
    .branch_nonresp(branch_nonresp), .loss_count(loss_count),
    .nonresp_drop_count(nonresp_drop_count), .upstream_reject_count(upstream_reject_count)
  );

  leaf_far_model u_leaf (
    .clk(core_clk), .out_valid(leaf_out_valid), .out_ready(leaf_out_ready),
    .out_kind(leaf_out_kind), .out_payload(leaf_out_payload),
    .in_valid(leaf_in_valid), .in_kind(leaf_in_kind), .in_payload(leaf_in_payload),
    .stall(stall), .cnt(m_cnt), .hsh(m_hsh), .last_kind(m_kind)
  );

  // ********
  // clock, watchdog and root-side monitor
  // ********
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cycles, 0);
      end_sim();
    end
  end

  always @(posedge core_clk) begin
    if (root_bk_valid === 1'b1 && root_bk_ready === 1'b1) begin
      bk_cnt <= bk_cnt + 1;
      bk_pay <= root_bk_payload;
      bk_kind <= root_bk_kind;
    end
  end

  // ********
  // shared tasks
  // ********
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // valid drops while the buffer is full, so no loss is counted by accident
  task automatic send(input cell_kind_t k, input logic [15:0] p);
    while (root_in_ready !== 1'b1) begin
      root_in_valid = 1'b0;
      @(negedge core_clk);
    end
    root_in_valid = 1'b1;
    root_in_kind = k;
    root_in_payload = p;
    @(negedge core_clk);
  endtask : send

  task automatic idle(input int n);
    root_in_valid = 1'b0;
    root_in_kind = cell_kind_t'(~root_in_kind);
    root_in_payload = ~root_in_payload;
    repeat (n) @(negedge core_clk);
  endtask : idle

  task automatic exp_add(input logic [3:0] mask, input logic [15:0] p);
    for (int i = 0; i < 4; i++) begin
      if (mask[i]) begin
        exp_cnt[i] = exp_cnt[i] + 16'h0001;
        exp_hsh[i] = {exp_hsh[i][14:0], exp_hsh[i][15]} ^ p;
      end
    end
  endtask : exp_add

  task automatic chk_leaves;
    for (int i = 0; i < 4; i++) begin
      chk(m_cnt[i], exp_cnt[i]);
      chk(m_hsh[i], exp_hsh[i]);
    end
  endtask : chk_leaves

  // exactly one more backward cell must reach the root
  task automatic wait_bk(input int n0);
    while (bk_cnt == n0) @(negedge core_clk);
    idle(3);
    chk(16'(bk_cnt - n0), 16'h0001);
  endtask : wait_bk

  // ********
  // scenarios
  // ********
  task automatic t_replicate;
    send(CELL_DATA, 16'h1234);
    send(CELL_FRM, 16'h0ABC);
    idle(6);
    exp_add(4'hF, 16'h1234);
    exp_add(4'hF, 16'h0ABC);
    chk_leaves();
    chk({14'h0, m_kind[3]}, 16'h0001);
    $display("test replicate done");
  endtask : t_replicate

  task automatic t_consolidate;
    int n0;
    n0 = bk_cnt;
    root_bk_ready = 1'b0;
    u_leaf.report(4'hF, CELL_BRM, 64'h0320_0100_0200_0180);
    idle(6);
    chk({15'h0, root_bk_valid}, 16'h0001);
    chk(16'(bk_cnt - n0), 16'h0000);
    root_bk_ready = 1'b1;
    wait_bk(n0);
    chk(bk_pay, 16'h0100);
    chk({14'h0, bk_kind}, 16'h0002);
    $display("test consolidate done");
  endtask : t_consolidate

  task automatic t_upstream;
    int n0;
    logic [15:0] r0;
    n0 = bk_cnt;
    r0 = upstream_reject_count;
    u_leaf.report(4'h1, CELL_DATA, 64'h0);
    u_leaf.report(4'h2, CELL_FRM, 64'h0);
    cfg_ret_zero_rate = 1'b1;
    u_leaf.report(4'hF, CELL_BRM, 64'h0);
    idle(3);
    chk(upstream_reject_count - r0, 16'h0006);
    chk(16'(bk_cnt - n0), 16'h0000);
    u_leaf.report(4'hF, CELL_BRM_OOR, 64'h01F4_0190_01C2_01A4);
    wait_bk(n0);
    chk(bk_pay, 16'h0190);
    chk({14'h0, bk_kind}, 16'h0003);
    cfg_ret_zero_rate = 1'b0;
    $display("test upstream done");
  endtask : t_upstream

  task automatic t_nonresp;
    int n0;
    logic [15:0] d0, l0;
    idle(IDLE + 5);
    chk({12'h0, branch_nonresp}, 16'h000F);
    n0 = bk_cnt;
    d0 = nonresp_drop_count;
    l0 = loss_count;
    u_leaf.report(4'h7, CELL_BRM, 64'h0000_00FA_00C8_012C);
    wait_bk(n0);
    chk(bk_pay, 16'h00C8);
    chk({12'h0, branch_nonresp}, 16'h0008);
    // the silent branch holds its first copy and so loses the second
    stall = 4'h8;
    send(CELL_DATA, 16'h0055);
    send(CELL_DATA, 16'h0066);
    idle(6);
    exp_add(4'hF, 16'h0055);
    exp_add(4'h7, 16'h0066);
    chk(nonresp_drop_count - d0, 16'h0001);
    chk(loss_count - l0, 16'h0000);
    stall = 4'h0;
    idle(3);
    chk_leaves();
    $display("test nonresp done");
  endtask : t_nonresp

  task automatic t_fill;
    int n0;
    int n;
    logic [15:0] l0;
    n0 = bk_cnt;
    n = 0;
    u_leaf.report(4'hF, CELL_BRM, 64'h0400_0400_0400_0400);
    wait_bk(n0);
    l0 = loss_count;
    stall = 4'hF;
    while (root_in_ready === 1'b1 && n < 16) begin
      send(CELL_DATA, 16'h0A00 + 16'(n));
      exp_add(4'hF, 16'h0A00 + 16'(n));
      n++;
    end
    // valid held for two refused cycles on purpose
    repeat (2) @(negedge core_clk);
    idle(1);
    chk({15'h0, n >= 4}, 16'h0001);
    chk(loss_count - l0, 16'h0002);
    stall = 4'h0;
    idle(n + 6);
    chk_leaves();
    $display("test fill done");
  endtask : t_fill

  task automatic t_vs;
    int n0;
    n0 = bk_cnt;
    cfg_vs_enable = 1'b1;
    send(CELL_FRM, 16'h0777);
    idle(1);
    wait_bk(n0);
    chk(bk_pay, 16'hFFFF);
    send(CELL_DATA, 16'h0888);
    idle(6);
    exp_add(4'hF, 16'h0888);
    chk_leaves();
    cfg_vs_enable = 1'b0;
    $display("test vs done");
  endtask : t_vs

  // ********
  // main sequence
  // ********
  initial begin
    arst_n = 1'b0;
    root_in_valid = 1'b0;
    root_in_kind = CELL_DATA;
    root_in_payload = 16'h0000;
    root_bk_ready = 1'b1;
    cfg_vs_enable = 1'b0;
    cfg_ret_zero_rate = 1'b0;
    stall = 4'h0;
    for (int i = 0; i < 4; i++) begin
      exp_cnt[i] = 16'h0000;
      exp_hsh[i] = 16'h0000;
    end
    repeat (2) @(negedge core_clk);
    chk({14'h0, root_bk_kind}, 16'h0002);
    arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({12'h0, leaf_in_ready}, 16'h000F);
    t_replicate();
    t_consolidate();
    t_upstream();
    t_nonresp();
    t_fill();
    t_vs();
    chk({12'h0, leaf_in_ready}, 16'h000F);
    end_sim();
  end
endmodule : tb_top
